// ==== hw/reset_source_logic.sv ====
// reset source combining, cause recording and restart delay
`timescale 1ns/1ps
`include "rst_seq_defines.svh"

module reset_source_logic #(
	parameter int unsigned LV_RESTART_CYCLES  = `LV_RESTART_CYCLES,
	parameter int unsigned WDT_RESTART_CYCLES = `WDT_RESTART_CYCLES,
	parameter int unsigned PIN_RESTART_CYCLES = `PIN_RESTART_CYCLES,
	parameter int unsigned LV_QUALIFY_CYCLES  = `LV_QUALIFY_CYCLES
) (
	// clock and power-on reset
	input  wire logic                  sys_clk,
	input  wire logic                  rst,
	// register port
	input  wire rst_seq_pkg::reg_req_s reg_req,
	output logic [7:0]                 reg_rdata,
	// reset sources
	input  wire logic                  external_reset_pin_n,
	input  wire logic                  supply_low,
	input  wire logic                  power_down,
	input  wire logic                  wdt_timeout,
	input  wire logic                  wdt_ctrl_invalid,
	input  wire logic                  slow_osc_clock,
	input  wire logic                  timeout_flag_clear,
	// device side
	output logic                       device_reset,
	output logic                       pc_clear,
	output logic                       timeout_status_flag,
	output logic                       lv_monitor_enable,
	output logic [7:0]                 lv_threshold_code,
	output logic                       irq
);

	////////////////////////////////////////////////////////////////////////////
	// registers

	rst_seq_pkg::seq_state_e  state;
	rst_seq_pkg::seq_state_e  next_state;
	logic [`DELAY_WIDTH-1:0]  delay_cnt;
	logic [`DELAY_WIDTH-1:0]  next_delay_cnt;
	logic [`DELAY_WIDTH-1:0]  qualify_cnt;
	logic [1:0]               slow_edges;
	logic                     slow_q;
	logic                     slow_rise;
	logic                     pend_lv;
	logic                     pend_code;
	logic                     pend_wdtc;
	logic                     code_valid;
	logic                     lv_qualified;
	logic                     fire;
	logic                     enter_wdt;
	logic                     enter_pin;
	logic [`CAUSE_WIDTH-1:0]  cause;
	logic [`CAUSE_WIDTH-1:0]  cause_set;
	logic [`IRQ_WIDTH-1:0]    irq_status;
	logic [`IRQ_WIDTH-1:0]    irq_mask;
	logic [`IRQ_WIDTH-1:0]    irq_events;
	logic                     wr_thr;
	logic                     wr_cause;
	logic                     wr_stat;
	logic                     wr_mask;

	////////////////////////////////////////////////////////////////////////////
	// decode

	always_comb begin
		wr_thr   = 1'b0;
		wr_cause = 1'b0;
		wr_stat  = 1'b0;
		wr_mask  = 1'b0;
		if (reg_req.wr && reg_req.addr == `OFS_LV_THRESHOLD) begin
			wr_thr = 1'b1;
		end else if (reg_req.wr && reg_req.addr == `OFS_RESET_CAUSE) begin
			wr_cause = 1'b1;
		end else if (reg_req.wr && reg_req.addr == `OFS_IRQ_STATUS) begin
			wr_stat = 1'b1;
		end else if (reg_req.wr && reg_req.addr == `OFS_IRQ_MASK) begin
			wr_mask = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// threshold select and low-voltage qualification

	always_comb begin
		case (lv_threshold_code)
			`LV_CODE_2V10, `LV_CODE_2V55, `LV_CODE_3V15, `LV_CODE_3V80: code_valid = 1'b1;
			default: code_valid = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			lv_threshold_code <= `LV_THRESHOLD_POR;
		end else if (fire && pend_code) begin
			lv_threshold_code <= `LV_THRESHOLD_POR;
		end else if (wr_thr) begin
			// a genuine low-voltage reset leaves the code alone
			lv_threshold_code <= reg_req.wdata;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			lv_monitor_enable <= 1'b1;
		end else begin
			lv_monitor_enable <= ~power_down;
		end
	end

	// short dips never reach the threshold count
	always_ff @(posedge sys_clk) begin
		if (rst || !supply_low || !lv_monitor_enable || state != rst_seq_pkg::st_run) begin
			qualify_cnt <= '0;
		end else if (!lv_qualified) begin
			qualify_cnt <= qualify_cnt + 1'b1;
		end
	end
	assign lv_qualified = qualify_cnt >= LV_QUALIFY_CYCLES[`DELAY_WIDTH-1:0];

	////////////////////////////////////////////////////////////////////////////
	// slow oscillator edge counting

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			slow_q <= 1'b0;
		end else begin
			slow_q <= slow_osc_clock;
		end
	end
	assign slow_rise = slow_osc_clock & ~slow_q;

	always_ff @(posedge sys_clk) begin
		if (rst || state != rst_seq_pkg::st_sync) begin
			slow_edges <= 2'd0;
		end else if (slow_rise) begin
			slow_edges <= slow_edges + 2'd1;
		end
	end
	// detection lands between edges, so the second edge is 1 to 2 slow periods on
	assign fire = state == rst_seq_pkg::st_sync && slow_rise
		&& slow_edges == `SLOW_EDGES_TO_RESET - 2'd1;

	// pending causes track the live conditions while running; all that stand are recorded
	always_ff @(posedge sys_clk) begin
		if (rst || state == rst_seq_pkg::st_pin_hold || fire) begin
			pend_lv   <= 1'b0;
			pend_code <= 1'b0;
			pend_wdtc <= 1'b0;
		end else if (state == rst_seq_pkg::st_run) begin
			pend_lv   <= lv_qualified;
			pend_code <= ~code_valid;
			pend_wdtc <= wdt_ctrl_invalid;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sequencer

	// a time-out in the sync wait is still normal operation and must not be lost
	assign enter_wdt = external_reset_pin_n && wdt_timeout
		&& (state == rst_seq_pkg::st_run || state == rst_seq_pkg::st_sync);
	assign enter_pin = state == rst_seq_pkg::st_pin_hold && external_reset_pin_n;

	always_comb begin
		next_state     = state;
		next_delay_cnt = delay_cnt;
		if (!external_reset_pin_n) begin
			next_state = rst_seq_pkg::st_pin_hold;
		end else begin
			case (state)
				rst_seq_pkg::st_run: begin
					if (wdt_timeout) begin
						next_state     = rst_seq_pkg::st_delay;
						next_delay_cnt = WDT_RESTART_CYCLES[`DELAY_WIDTH-1:0];
					end else if (lv_qualified || !code_valid || wdt_ctrl_invalid) begin
						next_state = rst_seq_pkg::st_sync;
					end
				end
				rst_seq_pkg::st_pin_hold: begin
					next_state     = rst_seq_pkg::st_delay;
					next_delay_cnt = PIN_RESTART_CYCLES[`DELAY_WIDTH-1:0];
				end
				rst_seq_pkg::st_sync: begin
					// execution still runs here, so the watchdog keeps its priority
					if (wdt_timeout) begin
						next_state     = rst_seq_pkg::st_delay;
						next_delay_cnt = WDT_RESTART_CYCLES[`DELAY_WIDTH-1:0];
					end else if (fire) begin
						next_state     = rst_seq_pkg::st_delay;
						next_delay_cnt = LV_RESTART_CYCLES[`DELAY_WIDTH-1:0];
					end
				end
				rst_seq_pkg::st_delay: begin
					if (delay_cnt <= {{(`DELAY_WIDTH-1){1'b0}}, 1'b1}) begin
						next_state     = rst_seq_pkg::st_run;
						next_delay_cnt = '0;
					end else begin
						next_delay_cnt = delay_cnt - 1'b1;
					end
				end
				default: begin
					next_state = rst_seq_pkg::st_run;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state     <= rst_seq_pkg::st_delay;
			delay_cnt <= PIN_RESTART_CYCLES[`DELAY_WIDTH-1:0];
		end else begin
			state     <= next_state;
			delay_cnt <= next_delay_cnt;
		end
	end

	// the sync wait is not yet a reset; execution continues until the edge
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			device_reset <= 1'b1;
			pc_clear     <= 1'b1;
		end else begin
			device_reset <= next_state == rst_seq_pkg::st_pin_hold
				|| next_state == rst_seq_pkg::st_delay;
			pc_clear     <= next_state == rst_seq_pkg::st_pin_hold
				|| next_state == rst_seq_pkg::st_delay;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			timeout_status_flag <= 1'b0;
		end else if (enter_wdt) begin
			timeout_status_flag <= 1'b1;
		end else if (timeout_flag_clear) begin
			timeout_status_flag <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// reset cause flags, survive every reset except power-on

	always_comb begin
		cause_set                   = '0;
		cause_set[`CAUSE_WDT_CTRL]  = fire && pend_wdtc;
		cause_set[`CAUSE_LV_SELECT] = fire && pend_code;
		cause_set[`CAUSE_LV_EVENT]  = fire && pend_lv;
	end

	// one flag cell per bit; a written one leaves its bit alone
	for (genvar g = 0; g < `CAUSE_WIDTH; g++) begin : g_cause
		cause_flag_bit i_cause_flag_bit (
			.sys_clk (sys_clk),
			.rst     (rst),
			.set     (cause_set[g]),
			.wr      (wr_cause),
			.wr_bit  (reg_req.wdata[g]),
			.flag    (cause[g])
		);
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupts

	always_comb begin
		irq_events                   = '0;
		irq_events[`IRQ_WDT_CTRL]    = fire && pend_wdtc;
		irq_events[`IRQ_LV_SELECT]   = fire && pend_code;
		irq_events[`IRQ_LV_EVENT]    = fire && pend_lv;
		irq_events[`IRQ_PIN_RESET]   = enter_pin;
		irq_events[`IRQ_WDT_TIMEOUT] = enter_wdt;
	end

	// set wins over a write-one clear in the same cycle
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			irq_status <= '0;
		end else if (wr_stat) begin
			irq_status <= (irq_status & ~reg_req.wdata[`IRQ_WIDTH-1:0]) | irq_events;
		end else begin
			irq_status <= irq_status | irq_events;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			irq_mask <= '0;
		end else if (wr_mask) begin
			irq_mask <= reg_req.wdata[`IRQ_WIDTH-1:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status & irq_mask);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read data

	always_ff @(posedge sys_clk) begin
		if (rst || !reg_req.rd) begin
			reg_rdata <= 8'h00;
		end else if (reg_req.addr == `OFS_LV_THRESHOLD) begin
			reg_rdata <= lv_threshold_code;
		end else if (reg_req.addr == `OFS_RESET_CAUSE) begin
			reg_rdata <= {5'h00, cause};
		end else if (reg_req.addr == `OFS_IRQ_STATUS) begin
			reg_rdata <= {3'h0, irq_status};
		end else begin
			reg_rdata <= {3'h0, irq_mask};
		end
	end

endmodule

////////////////////////////////////////////////////////////////////////////
// reset-cause flag cell
//
// hardware sets, software clears with a zero; writing ones to the bits to keep
// lets software clear one cause without touching the others

module cause_flag_bit #(
	parameter logic INIT = 1'b0
) (
	// clock and power-on reset
	input  wire logic sys_clk,
	input  wire logic rst,
	// hardware event
	input  wire logic set,
	// software write of this bit
	input  wire logic wr,
	input  wire logic wr_bit,
	// stored flag
	output logic      flag
);

	// set wins over a clearing write landing in the same cycle
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			flag <= INIT;
		end else if (set) begin
			flag <= 1'b1;
		end else if (wr && !wr_bit) begin
			flag <= 1'b0;
		end
	end

endmodule

// ==== hw/rst_seq_defines.svh ====
// offsets, field positions, reset values and timing counts of the reset source logic
`ifndef RST_SEQ_DEFINES_SVH
`define RST_SEQ_DEFINES_SVH

// register word offsets
`define OFS_LV_THRESHOLD   2'h0
`define OFS_RESET_CAUSE    2'h1
`define OFS_IRQ_STATUS     2'h2
`define OFS_IRQ_MASK       2'h3

// threshold-select codes
`define LV_CODE_2V10       8'h55
`define LV_CODE_2V55       8'h33
`define LV_CODE_3V15       8'h99
`define LV_CODE_3V80       8'hAA
`define LV_THRESHOLD_POR   8'h55

// reset-cause bit positions
`define CAUSE_WDT_CTRL     0
`define CAUSE_LV_SELECT    1
`define CAUSE_LV_EVENT     2
`define CAUSE_WIDTH        3

// interrupt status bit positions
`define IRQ_WDT_CTRL       0
`define IRQ_LV_SELECT      1
`define IRQ_LV_EVENT       2
`define IRQ_PIN_RESET      3
`define IRQ_WDT_TIMEOUT    4
`define IRQ_WIDTH          5

// slow oscillator edges from detection to reset
`define SLOW_EDGES_TO_RESET 2'd2

// timing
`define CLK_PERIOD_NS      20
`define LV_RESTART_NS      50000000
`define WDT_RESTART_NS     16700000
`define PIN_RESTART_NS     50000000
`define LV_QUALIFY_NS      120000
`define LV_RESTART_CYCLES  ((`LV_RESTART_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WDT_RESTART_CYCLES ((`WDT_RESTART_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PIN_RESTART_CYCLES ((`PIN_RESTART_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LV_QUALIFY_CYCLES  ((`LV_QUALIFY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DELAY_WIDTH        22

`endif

// ==== hw/rst_seq_pkg.sv ====
// types shared by the reset source logic
package rst_seq_pkg;

	typedef enum logic [1:0] {
		st_run,
		st_pin_hold,
		st_sync,
		st_delay
	} seq_state_e;

	typedef struct packed {
		logic [1:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_s;

endpackage

// ==== verif/reset_source_logic_properties.sv ====
// port assertions for the reset source logic
`timescale 1ns/1ps
module reset_source_logic_checker #(
	parameter int unsigned LV_RESTART_CYCLES  = 20,
	parameter int unsigned WDT_RESTART_CYCLES = 10
) (
	// clock and reset
	input wire logic                  sys_clk,
	input wire logic                  rst,
	// register port
	input wire rst_seq_pkg::reg_req_s reg_req,
	input wire logic [7:0]            reg_rdata,
	// sources
	input wire logic                  external_reset_pin_n,
	input wire logic                  power_down,
	input wire logic                  wdt_timeout,
	input wire logic                  timeout_flag_clear,
	// device side
	input wire logic                  device_reset,
	input wire logic                  pc_clear,
	input wire logic                  timeout_status_flag,
	input wire logic                  lv_monitor_enable,
	input wire logic [7:0]            lv_threshold_code
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	// held cycles since the pin went high; a pin hold restarts the count
	int unsigned hi_cnt;
	always_ff @(posedge sys_clk) begin
		if (rst || !device_reset || !external_reset_pin_n)
			hi_cnt <= 0;
		else
			hi_cnt <= hi_cnt + 1;
	end
	AST_PIN_HOLD: assert property (
		!external_reset_pin_n [*2] |-> device_reset && pc_clear)
		else $error("device ran with reset pin low");
	AST_PC_CLEAR: assert property (pc_clear == device_reset)
		else $error("program counter clear apart from reset");
	AST_DELAY: assert property ($fell(device_reset) |->
		hi_cnt >= WDT_RESTART_CYCLES - 2 && hi_cnt <= LV_RESTART_CYCLES + 3)
		else $error("restart delay length out of range");
	AST_WDT_FLAG: assert property (wdt_timeout && !device_reset &&
		external_reset_pin_n && !timeout_flag_clear
		|=> ##[0:1] timeout_status_flag && device_reset)
		else $error("watchdog time-out without flag and reset");
	AST_THR_POR: assert property (disable iff (1'h0)
		rst |=> lv_threshold_code == 8'h55)
		else $error("threshold not at power-on value");
	AST_CODE_WR: assert property (reg_req.wr && reg_req.addr == 2'h0 &&
		reg_req.wdata inside {8'h55, 8'h33, 8'h99, 8'haa}
		|=> lv_threshold_code == $past(reg_req.wdata))
		else $error("valid threshold code not taken");
	AST_CAUSE_HI: assert property (
		reg_req.rd && reg_req.addr == 2'h1 |=> reg_rdata[7:3] == 5'h00)
		else $error("unused cause bits read nonzero");
	AST_MON_OFF: assert property (power_down |=> !lv_monitor_enable)
		else $error("monitor on in power-down");
endmodule

bind reset_source_logic reset_source_logic_checker #(
	.LV_RESTART_CYCLES (LV_RESTART_CYCLES), .WDT_RESTART_CYCLES (WDT_RESTART_CYCLES)
) i_reset_source_logic_checker (
	.sys_clk (sys_clk), .rst (rst), .reg_req (reg_req), .reg_rdata (reg_rdata),
	.external_reset_pin_n (external_reset_pin_n), .power_down (power_down),
	.wdt_timeout (wdt_timeout), .timeout_flag_clear (timeout_flag_clear),
	.device_reset (device_reset), .pc_clear (pc_clear),
	.timeout_status_flag (timeout_status_flag), .lv_monitor_enable (lv_monitor_enable),
	.lv_threshold_code (lv_threshold_code)
);

// ==== verif/rc_reset_net.sv ====
// external rc network in front of the reset pin
`timescale 1ns/1ps
module rc_reset_net (
	// clock
	input wire logic       sys_clk,
	// press request and how long the capacitor holds the pin
	input wire logic       press,
	input wire logic [7:0] hold_len,
	// pin, pulled up by the resistor once released
	output logic           external_reset_pin_n
);
	int unsigned left = 0;
	initial external_reset_pin_n = 1'h1;
	always @(posedge sys_clk) begin
		if (press)
			left <= hold_len;
		else if (left != 0)
			left <= left - 1;
		external_reset_pin_n <= !(press || left > 1);
	end
endmodule

// ==== verif/test_reset_source_logic.sv ====
// self-checking bench of the reset source logic
`timescale 1ns/1ps
module test_reset_source_logic;
	localparam int unsigned LV = 20, WD = 10, PN = 15, QL = 5;
	logic                  sys_clk = '0, rst = '1, pin_n, press = '0;
	rst_seq_pkg::reg_req_s req = '0;
	logic [7:0]            reg_rdata, thr, thr_code, hold_len = 8'h06, q[$];
	logic                  supply_low = '0, power_down = '0, wdt_timeout = '0;
	logic                  wdt_ctrl_invalid = '0, slow = '0, to_clr = '0, rd_d = '0;
	logic                  device_reset, pc_clear, to_flag, mon_en, irq;
	logic [7:0]            codes [4] = '{8'h55, 8'h33, 8'h99, 8'haa};
	logic [31:0]           seed = 32'h0000_dd5d;
	int                    n_mismatch = 0, n_tests = 0, cyc = 0, n;

	reset_source_logic #(.LV_RESTART_CYCLES (LV), .WDT_RESTART_CYCLES (WD),
		.PIN_RESTART_CYCLES (PN), .LV_QUALIFY_CYCLES (QL)) i_reset_source_logic (
		.sys_clk (sys_clk), .rst (rst), .reg_req (req), .reg_rdata (reg_rdata),
		.external_reset_pin_n (pin_n), .supply_low (supply_low),
		.power_down (power_down), .wdt_timeout (wdt_timeout),
		.wdt_ctrl_invalid (wdt_ctrl_invalid), .slow_osc_clock (slow),
		.timeout_flag_clear (to_clr), .device_reset (device_reset), .pc_clear (pc_clear),
		.timeout_status_flag (to_flag), .lv_monitor_enable (mon_en),
		.lv_threshold_code (thr_code), .irq (irq));
	rc_reset_net i_rc_reset_net (.sys_clk (sys_clk), .press (press),
		.hold_len (hold_len), .external_reset_pin_n (pin_n));

	////////////////////////////////////////
	initial forever #10 sys_clk = ~sys_clk;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// slow oscillator at an eighth of the clock; read data checked a cycle after the strobe
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		slow <= cyc[2];
		rd_d <= req.rd;
		if (rd_d)
			chk(reg_rdata, q.pop_front());
		if (cyc == 20000) begin
			n_mismatch++;
			print_verdict();
		end
	end

	////////////////////////////////////////
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		req <= '{a, d, 1'h1, 1'h0};
		@(posedge sys_clk);
		req <= '0;
	endtask
	task automatic rd(input logic [1:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		req <= '{a, 8'h00, 1'h0, 1'h1};
		q.push_back(e);
		@(posedge sys_clk);
		req <= '0;
	endtask
	// bounded, so a reset that never comes shows up as a wrong count
	task automatic until_rst(input logic lvl, output int k);
		for (k = 0; k < 300 && device_reset !== lvl; k++)
			@(posedge sys_clk);
	endtask

	////////////////////////////////////////
	initial begin
		repeat (12) @(posedge sys_clk);
		rst <= '0;
		rd(2'h0, 8'h55);
		rd(2'h1, 8'h00);
		until_rst(0, n);
		$display("test power-on done");
		n = rnd() % 4;
		for (int i = 0; i < 4; i++) begin
			wr(2'h0, codes[(n + i) % 4]);
			rd(2'h0, codes[(n + i) % 4]);
		end
		wr(2'h1, 8'hff);
		rd(2'h1, 8'h00);
		$display("test codes done");
		@(posedge sys_clk);
		press <= 1'h1;
		hold_len <= 8'(4 + rnd() % 8);
		@(posedge sys_clk);
		press <= 1'h0;
		repeat (3) @(posedge sys_clk);
		chk(device_reset, 1);
		chk(pc_clear, 1);
		for (n = 0; n < 30 && !pin_n; n++)
			@(posedge sys_clk);
		until_rst(0, n);
		chk(n >= PN - 1 && n <= PN + 3, 1);
		rd(2'h2, 8'h08);
		chk(irq, 0);
		wr(2'h3, 8'h08);
		repeat (2) @(posedge sys_clk);
		chk(irq, 1);
		wr(2'h2, 8'h08);
		repeat (2) @(posedge sys_clk);
		chk(irq, 0);
		$display("test pin done");
		@(posedge sys_clk);
		wdt_timeout <= 1'h1;
		@(posedge sys_clk);
		wdt_timeout <= 1'h0;
		until_rst(1, n);
		chk(to_flag, 1);
		until_rst(0, n);
		chk(n >= WD - 2 && n <= WD + 2, 1);
		to_clr <= 1'h1;
		@(posedge sys_clk);
		to_clr <= 1'h0;
		repeat (2) @(posedge sys_clk);
		chk(to_flag, 0);
		$display("test watchdog done");
		wr(2'h0, 8'h12);
		until_rst(1, n);
		chk(n >= 4 && n <= 24, 1);
		until_rst(0, n);
		chk(n >= LV - 2 && n <= LV + 2, 1);
		rd(2'h0, 8'h55);
		chk(thr_code, 8'h55);
		rd(2'h1, 8'h02);
		wr(2'h1, 8'hff);
		rd(2'h1, 8'h02);
		wr(2'h1, 8'h00);
		wdt_ctrl_invalid <= 1'h1;
		until_rst(1, n);
		wdt_ctrl_invalid <= 1'h0;
		until_rst(0, n);
		rd(2'h1, 8'h01);
		wr(2'h1, 8'h00);
		$display("test invalid codes done");
		thr = codes[rnd() % 4];
		wr(2'h0, thr);
		supply_low <= 1'h1;
		repeat (3) @(posedge sys_clk);
		supply_low <= 1'h0;
		repeat (30) @(posedge sys_clk);
		chk(device_reset, 0);
		power_down <= 1'h1;
		supply_low <= 1'h1;
		repeat (40) @(posedge sys_clk);
		chk(mon_en, 0);
		chk(device_reset, 0);
		power_down <= 1'h0;
		until_rst(1, n);
		supply_low <= 1'h0;
		chk(n >= QL && n <= QL + 28, 1);
		until_rst(0, n);
		rd(2'h1, 8'h04);
		rd(2'h0, thr);
		chk(thr_code, thr);
		repeat (3) @(posedge sys_clk);
		$display("test low voltage done");
		print_verdict();
	end
endmodule
